// [shared/bcpc_pkg.sv]
// Constants, register map and state codes of the charge path controller
package bcpc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_PATH   = 8'h01;
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] ADDR_CTRL   = 8'h03;
   localparam logic [7:0] ADDR_OPT    = 8'h04;
   localparam logic [7:0] ADDR_LIMIT  = 8'h05;
   // Field positions
   localparam int PATH_MAINS_DRAIN = 7;
   localparam int PATH_BUS_DRAIN   = 6;
   localparam int CTRL_ENABLE      = 0;
   localparam int CTRL_SAFETY_CLK  = 1;
   localparam int CTRL_END_DISABLE = 2;
   localparam int CTRL_RESTART     = 3;
   localparam int CTRL_FAST_TIME   = 4;
   localparam int OPT_SLOWDOWN     = 0;
   localparam int LIM_END_CURRENT  = 0;
   localparam int LIM_PRE_TIME     = 2;
   localparam int LIM_TEMP_WINDOW  = 4;
   localparam int LIM_FAST_CURRENT = 6;
   localparam int STAT_DONE        = 0;
   localparam int STAT_FAST_TOUT   = 1;
   localparam int STAT_PRE_TOUT    = 2;
   localparam int STAT_TEMP_ERR    = 3;
   localparam int STAT_PHASE       = 4;
   // Reset values
   localparam logic [7:0] PATH_RST  = 8'h00;
   localparam logic [7:0] CTRL_RST  = 8'h03;
   localparam logic [7:0] OPT_RST   = 8'h01;
   localparam logic [7:0] LIMIT_RST = 8'h01;
   // End current codes: 0 = 2.5 %, 1 = 7.5 % (default)
   localparam logic [1:0] END_CODE_LOWEST = 2'h0;
   localparam logic [1:0] END_CODE_7P5    = 2'h1;
   // Timing
   localparam int CLK_HZ      = 200000000;
   localparam int TICK_S      = 1;
   localparam int TICK_CYC    = TICK_S * CLK_HZ;
   localparam int DET_MS      = 250;
   localparam int DET_CYC     = DET_MS * (CLK_HZ / 1000);
   localparam int PRE_TIME_S  = 1800;
   localparam int FAST_TIME_S = 3600;
   localparam int PRE_TICKS   = PRE_TIME_S / TICK_S;
   localparam int FAST_TICKS  = FAST_TIME_S / TICK_S;
   // Input source selection
   typedef enum logic [2:0]
   {
      SRC_NONE = 3'h1,
      SRC_MAINS = 3'h2,
      SRC_BUS = 3'h4
   } bcpc_src_e;
   // Charge sequencer
   typedef enum logic [9:0]
   {
      CH_IDLE     = 10'h001,
      CH_SHORTCHK = 10'h002,
      CH_PRE      = 10'h004,
      CH_FAST     = 10'h008,
      CH_CV       = 10'h010,
      CH_DONE     = 10'h020,
      CH_DETECT   = 10'h040,
      CH_INS_SRC  = 10'h080,
      CH_INS_SINK = 10'h100,
      CH_FAULT    = 10'h200
   } bcpc_chg_e;
endpackage

// [testbench/bcpc_path_checker.sv]
// Port assertions for the charge path controller
`timescale 1ns/100ps
module bcpc_path_checker
   import bcpc_pkg::*;
(
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       regWrite,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       pathBlocked,
   input wire logic       loadLoopActive,
   input wire logic       thermalLoopActive,
   input wire logic       mainsPathOn,
   input wire logic       busPathOn,
   input wire logic       batteryToSys,
   input wire logic       mainsSinkOn,
   input wire logic       busSinkOn,
   input wire logic       chargeOn,
   input wire logic       chargeDone,
   input wire logic       preTimeout,
   input wire logic       fastTimeout,
   input wire logic       timerHalfRate,
   input wire logic [1:0] endCurrentCode,
   input wire logic [1:0] fastCurrentCode
);
   logic       forced;
   logic       next_forced;
   logic [7:0] limCopy;
   logic [7:0] next_limCopy;
   logic       wrLim;
   assign wrLim = regWrite && regAddr == ADDR_LIMIT;
   always_comb
   begin
      next_forced = forced;
      next_limCopy = limCopy;
      if (regWrite && regAddr == ADDR_PATH)
         next_forced = regWdata[PATH_MAINS_DRAIN] && regWdata[PATH_BUS_DRAIN];
      if (wrLim)
         next_limCopy = regWdata;
   end
   always_ff @(posedge mclk)
   begin
      forced <= reset_n && next_forced;
      limCopy <= reset_n ? next_limCopy : LIMIT_RST;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_one_path: assert property ($onehot({mainsPathOn, busPathOn, batteryToSys}))
      else $error("path select not one-hot");
   a_blocked_battery: assert property (pathBlocked [*3] |-> batteryToSys)
      else $error("blocked path without battery feed");
   a_sink_forced_off: assert property (forced && $past(forced) |-> !mainsSinkOn && !busSinkOn)
      else $error("drain sink on while forced off");
   a_sink_exclusive: assert property (!(mainsSinkOn && busSinkOn))
      else $error("both drain sinks on");
   a_done_stops: assert property ($rose(chargeDone) |-> !chargeOn)
      else $error("charging after done");
   a_timeout_stops: assert property ($rose(preTimeout) || $rose(fastTimeout) |-> !chargeOn)
      else $error("charging after timeout");
   a_half_rate_cause: assert property ((!loadLoopActive && !thermalLoopActive) [*8]
      |-> !timerHalfRate)
      else $error("half rate without loop");
   a_code_copy: assert property (wrLim ##1 !wrLim [*2] |-> endCurrentCode == limCopy[1:0]
      && fastCurrentCode == limCopy[7:6])
      else $error("current codes differ from field");
endmodule
bind bcpc_charge_path bcpc_path_checker bcpc_path_checker_inst (.*);

// [testbench/tb.sv]
// Self-checking bench for the charge path controller
`timescale 1ns/100ps
module tb;
   import bcpc_pkg::*;
   logic mclk = 1'h0, reset_n = 1'h0, regWrite = 1'h0, pathBlocked = 1'h0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
   logic mainsOver4v3 = 1'h0, busOver4v3 = 1'h0, mainsUnder4v1 = 1'h0, mainsUnderHold = 1'h0;
   logic busUnderHold = 1'h0, mainsOverBat190 = 1'h0, mainsUnderBat125 = 1'h0;
   logic busOverBat190 = 1'h0, busUnderBat125 = 1'h0, batUnder1v5 = 1'h0, batUnderUvlo = 1'h0;
   logic batOverShort = 1'h0, batOverLowv = 1'h0, batUnderRecharge = 1'h0, packCold = 1'h0;
   logic batAtRegulation = 1'h0, currentUnderEnd = 1'h0, loadLoopActive = 1'h0;
   logic thermalLoopActive = 1'h0, packOver45 = 1'h0, packOver60 = 1'h0;
   logic mainsPathOn, busPathOn, batteryToSys, mainsSinkOn, busSinkOn, chargeOn, preCurrentOn;
   logic testSourceOn, testSinkOn, timerHalfRate, chargeDone, fastTimeout, preTimeout;
   logic packTempError;
   logic [1:0] endCurrentCode, fastCurrentCode;
   int n_fail = 0, tests_run = 0;
   bcpc_charge_path #(.TICK_CYCLES(4), .DET_CYCLES(8), .PRE_LIMIT(3), .FAST_LIMIT(5))
      bcpc_charge_path_inst (.*);
   always #2.5 mclk = ~mclk;
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic chk(input logic [7:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic flg(input logic [1:0] got, exp);
      chk({6'h00, got}, {6'h00, exp});
   endtask
   task automatic wr(input logic [7:0] a, d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'h1;
      cyc(1);
      regWrite = 1'h0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      regAddr = a;
      cyc(1);
      chk(regRdata, exp);
   endtask
   task automatic t_regs();
      rd(ADDR_CTRL, CTRL_RST);
      rd(ADDR_OPT, OPT_RST);
      rd(ADDR_LIMIT, LIMIT_RST);
      rd(ADDR_PATH, PATH_RST);
      wr(8'h07, 8'hFF);
      rd(8'h07, 8'h00);
      wr(ADDR_LIMIT, 8'h80);
      cyc(2);
      flg(endCurrentCode, END_CODE_LOWEST);
      flg(fastCurrentCode, 2'h2);
      wr(ADDR_LIMIT, LIMIT_RST);
   endtask
   task automatic t_path();
      flg({batteryToSys, mainsPathOn}, 2'h2);
      batUnderUvlo = 1'h1;
      mainsOver4v3 = 1'h1;
      busOver4v3 = 1'h1;
      cyc(8);
      flg({mainsPathOn, busPathOn}, 2'h2);
      mainsOver4v3 = 1'h0;
      mainsUnder4v1 = 1'h1;
      cyc(8);
      flg({mainsPathOn, busPathOn}, 2'h2);
      batUnder1v5 = 1'h1;
      cyc(8);
      flg({mainsPathOn, busPathOn}, 2'h1);
      mainsUnderHold = 1'h1;
      cyc(8);
      flg({mainsSinkOn, busSinkOn}, 2'h2);
      wr(ADDR_PATH, 8'hC0);
      cyc(4);
      flg({mainsSinkOn, busSinkOn}, 2'h0);
      wr(ADDR_PATH, PATH_RST);
      {batUnderUvlo, batUnder1v5, mainsUnder4v1, mainsUnderHold, busOver4v3} = 5'h00;
      mainsOverBat190 = 1'h1;
      busOverBat190 = 1'h1;
      cyc(8);
      flg({mainsPathOn, busPathOn}, 2'h2);
      mainsOverBat190 = 1'h0;
      cyc(8);
      flg({mainsPathOn, busPathOn}, 2'h2);
      mainsUnderBat125 = 1'h1;
      cyc(8);
      flg({mainsPathOn, busPathOn}, 2'h1);
      pathBlocked = 1'h1;
      cyc(4);
      flg({batteryToSys, busPathOn}, 2'h2);
      pathBlocked = 1'h0;
   endtask
   task automatic t_charge();
      wr(ADDR_CTRL, 8'h09);
      cyc(2);
      flg({testSourceOn, chargeOn}, 2'h2);
      batOverShort = 1'h1;
      cyc(8);
      flg({chargeOn, preCurrentOn}, 2'h3);
      batOverLowv = 1'h1;
      cyc(40);
      flg({chargeOn, preCurrentOn}, 2'h2);
      packOver45 = 1'h1;
      cyc(8);
      flg({chargeOn, fastTimeout}, 2'h0);
      packOver45 = 1'h0;
      cyc(8);
      flg({chargeOn, fastTimeout}, 2'h2);
      {thermalLoopActive, batAtRegulation, currentUnderEnd} = 3'h7;
      cyc(8);
      flg({timerHalfRate, chargeDone}, 2'h2);
      wr(ADDR_OPT, 8'h00);
      cyc(2);
      flg({timerHalfRate, chargeDone}, 2'h0);
      thermalLoopActive = 1'h0;
      cyc(8);
      flg({chargeDone, chargeOn}, 2'h2);
      batUnderRecharge = 1'h1;
      cyc(6);
      flg({testSinkOn, chargeOn}, 2'h2);
      batUnderRecharge = 1'h0;
      currentUnderEnd = 1'h0;
      cyc(16);
      flg({testSinkOn, chargeOn}, 2'h1);
   endtask
   task automatic t_remove();
      wr(ADDR_CTRL, 8'h05);
      currentUnderEnd = 1'h1;
      cyc(8);
      flg({chargeDone, chargeOn}, 2'h1);
      wr(ADDR_CTRL, 8'h01);
      cyc(4);
      {batOverLowv, batUnderRecharge} = 2'h1;
      cyc(16);
      flg({packTempError, testSourceOn}, 2'h3);
   endtask
   task automatic t_tout();
      {batAtRegulation, batOverLowv, batUnderRecharge} = 3'h0;
      cyc(6);
      wr(ADDR_CTRL, 8'h0B);
      cyc(30);
      flg({preTimeout, chargeOn}, 2'h2);
      wr(ADDR_CTRL, 8'h0B);
      cyc(2);
      flg({preTimeout, chargeOn}, 2'h1);
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      wrap_up();
   end
   initial
   begin
      cyc(12);
      reset_n = 1'h1;
      t_regs();
      t_path();
      t_charge();
      t_remove();
      t_tout();
      wrap_up();
   end
endmodule

// [verilog/bcpc_charge_path.sv]
// Input path selection, drain sinks, charge sequencer and safety timers
// Operation
// RULE1: Shorted or absent battery: input valid once above 4.3 V.
// RULE2: Both inputs valid: draw from mains, not from bus input.
// RULE3: Shorted battery, both present: switch to bus input when mains below 4.1 V.
// RULE4: Dead battery: once mains selected, no fall back below 4.1 V.
// RULE5: Good battery: present at 190 mV above battery, absent under 125 mV.
// RULE6: No input or path blocked: battery feeds the system rail.
// RULE7: Drain sink on an input when other valid and this one undetected.
// RULE8: Both drain fields set forces both sinks off; mixed settings discouraged.
// RULE9: On enable, test current first; charge only above short threshold.
// RULE10: Precharge, then fast charge above threshold, then constant voltage.
// RULE11: Precharge current fixed at ten percent of fast current.
// RULE12: End current reached in constant voltage: set done, charger off.
// RULE13: Two-bit end current select, default 7.5 percent; avoid 2.5 percent.
// RULE14: Loop-reduced current: timer at half rate, termination disabled.
// RULE15: Slowdown enable cleared disables half rate; enabled after reset.
// RULE16: End disable: stay in constant voltage, no detection, no timers.
// RULE17: Safety clock enable cleared disables precharge and fast timers.
// RULE18: Below recharge: sink detection current; still present restarts cycle.
// RULE19: Battery removed: alternate test pulses until found, flag temp error.
// RULE20: Precharge and fast charge timeouts are declared and flagged.
// RULE21: Input rising, restart bit or below recharge clear faults, restart.
// RULE22: Outside temperature window: suspend, hold timer, resume on return.
`timescale 1ns/100ps
module bcpc_charge_path
   import bcpc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int DET_CYCLES  = DET_CYC,
   parameter int PRE_LIMIT   = PRE_TICKS,
   parameter int FAST_LIMIT  = FAST_TICKS
)
(
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       regWrite,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   output logic      [7:0] regRdata,
   input  wire logic       pathBlocked,
   input  wire logic       mainsOver4v3,
   input  wire logic       busOver4v3,
   input  wire logic       mainsUnder4v1,
   input  wire logic       mainsUnderHold,
   input  wire logic       busUnderHold,
   input  wire logic       mainsOverBat190,
   input  wire logic       mainsUnderBat125,
   input  wire logic       busOverBat190,
   input  wire logic       busUnderBat125,
   input  wire logic       batUnder1v5,
   input  wire logic       batUnderUvlo,
   input  wire logic       batOverShort,
   input  wire logic       batOverLowv,
   input  wire logic       batUnderRecharge,
   input  wire logic       batAtRegulation,
   input  wire logic       currentUnderEnd,
   input  wire logic       loadLoopActive,
   input  wire logic       thermalLoopActive,
   input  wire logic       packCold,
   input  wire logic       packOver45,
   input  wire logic       packOver60,
   output logic            mainsPathOn,
   output logic            busPathOn,
   output logic            batteryToSys,
   output logic            mainsSinkOn,
   output logic            busSinkOn,
   output logic            chargeOn,
   output logic            preCurrentOn,
   output logic            testSourceOn,
   output logic            testSinkOn,
   output logic            timerHalfRate,
   output logic      [1:0] endCurrentCode,
   output logic      [1:0] fastCurrentCode,
   output logic            chargeDone,
   output logic            fastTimeout,
   output logic            preTimeout,
   output logic            packTempError
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int DW = $clog2(DET_CYCLES + 1);
   localparam int SW = 20;

   // Filtered comparator pins
   logic [20:0] pinRaw;
   logic [20:0] pinF;
   assign pinRaw = {mainsOver4v3, busOver4v3, mainsUnder4v1, mainsUnderHold, busUnderHold,
                    mainsOverBat190, mainsUnderBat125, busOverBat190, busUnderBat125,
                    batUnder1v5, batUnderUvlo, batOverShort, batOverLowv, batUnderRecharge,
                    batAtRegulation, currentUnderEnd, loadLoopActive, thermalLoopActive,
                    packCold, packOver45, packOver60};

   bcpc_pin_filter #(.W(21)) pinSync
   (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pinIn   (pinRaw),
      .pinOut  (pinF)
   );

   logic fMOver43, fBOver43, fMUnder41, fMHold, fBHold, fMOver190, fMUnder125;
   logic fBOver190, fBUnder125, fShorted, fDead, fOverShort, fOverLowv, fUnderRch;
   logic fAtReg, fUnderEnd, fLoad, fThermal, fCold, fOver45, fOver60;
   assign {fMOver43, fBOver43, fMUnder41, fMHold, fBHold, fMOver190, fMUnder125,
           fBOver190, fBUnder125, fShorted, fDead, fOverShort, fOverLowv, fUnderRch,
           fAtReg, fUnderEnd, fLoad, fThermal, fCold, fOver45, fOver60} = pinF;

   function automatic logic [3:0] phaseCode(input bcpc_chg_e s);
      phaseCode = 4'h0;
      for (int i = 0; i < 10; i++)
      begin
         if (s[i])
         begin
            phaseCode = 4'(i);
         end
      end
   endfunction

   // Register file
   logic [7:0] pathCfg, ctrlCfg, optCfg, limitCfg;
   logic [7:0] next_pathCfg, next_ctrlCfg, next_optCfg, next_limitCfg, next_regRdata;
   logic       restartReq, next_restartReq;
   bcpc_chg_e  state, next_state;

   always_comb
   begin
      next_pathCfg    = pathCfg;
      next_ctrlCfg    = ctrlCfg;
      next_optCfg     = optCfg;
      next_limitCfg   = limitCfg;
      next_restartReq = 1'b0;
      if (regWrite)
      begin
         unique case (regAddr)
            ADDR_PATH:  next_pathCfg = regWdata;
            ADDR_CTRL:
            begin
               next_ctrlCfg = regWdata & ~(8'h01 << CTRL_RESTART);
               // RULE21: restart bit
               next_restartReq = regWdata[CTRL_RESTART];
            end
            ADDR_OPT:   next_optCfg = regWdata;
            ADDR_LIMIT: next_limitCfg = regWdata;
            default:    next_pathCfg = pathCfg;
         endcase
      end
      unique case (regAddr)
         ADDR_PATH:   next_regRdata = pathCfg;
         ADDR_STATUS: next_regRdata = {phaseCode(state), packTempError, preTimeout,
                                       fastTimeout, chargeDone};
         ADDR_CTRL:   next_regRdata = ctrlCfg;
         ADDR_OPT:    next_regRdata = optCfg;
         ADDR_LIMIT:  next_regRdata = limitCfg;
         default:     next_regRdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         pathCfg    <= PATH_RST;
         ctrlCfg    <= CTRL_RST;
         optCfg     <= OPT_RST;
         limitCfg   <= LIMIT_RST;
         restartReq <= 1'b0;
         regRdata   <= 8'h00;
      end
      else
      begin
         pathCfg    <= next_pathCfg;
         ctrlCfg    <= next_ctrlCfg;
         optCfg     <= next_optCfg;
         limitCfg   <= next_limitCfg;
         restartReq <= next_restartReq;
         regRdata   <= next_regRdata;
      end
   end

   // Input path
   bcpc_src_e src, next_src;
   logic mainsValid, busValid, next_mainsValid, next_busValid;
   logic mainsSeen, busSeen, next_mainsSinkOn, next_busSinkOn;

   always_comb
   begin
      next_mainsValid = mainsValid;
      next_busValid   = busValid;
      if (fDead)
      begin
         // RULE1: 4.3 V entry
         if (fMOver43) next_mainsValid = 1'b1;
         else if (fMHold) next_mainsValid = 1'b0;
         if (fBOver43) next_busValid = 1'b1;
         else if (fBHold) next_busValid = 1'b0;
         mainsSeen = fMOver43;
         busSeen   = fBOver43;
      end
      else
      begin
         // RULE5: battery-relative hysteresis
         if (fMOver190) next_mainsValid = 1'b1;
         else if (fMUnder125) next_mainsValid = 1'b0;
         if (fBOver190) next_busValid = 1'b1;
         else if (fBUnder125) next_busValid = 1'b0;
         mainsSeen = fMOver190;
         busSeen   = fBOver190;
      end
      // RULE6: battery feeds the rail
      if (pathBlocked || (!next_mainsValid && !next_busValid))
         next_src = SRC_NONE;
      else if (!next_busValid)
         next_src = SRC_MAINS;
      else if (!next_mainsValid)
         next_src = SRC_BUS;
      // RULE3: shorted battery falls back
      else if (fShorted && fMUnder41)
         next_src = SRC_BUS;
      // RULE4: dead battery keeps mains
      else if (fDead && fMUnder41)
         next_src = (src == SRC_MAINS) ? SRC_MAINS : SRC_BUS;
      // RULE2: mains has priority
      else
         next_src = SRC_MAINS;
      // RULE7: drain the undetected input
      next_mainsSinkOn = next_busValid && !mainsSeen;
      next_busSinkOn   = next_mainsValid && !busSeen;
      // RULE8: both fields set forces off
      if (pathCfg[PATH_MAINS_DRAIN] && pathCfg[PATH_BUS_DRAIN])
      begin
         next_mainsSinkOn = 1'b0;
         next_busSinkOn   = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         src          <= SRC_NONE;
         mainsValid   <= 1'b0;
         busValid     <= 1'b0;
         mainsPathOn  <= 1'b0;
         busPathOn    <= 1'b0;
         batteryToSys <= 1'b1;
         mainsSinkOn  <= 1'b0;
         busSinkOn    <= 1'b0;
      end
      else
      begin
         src          <= next_src;
         mainsValid   <= next_mainsValid;
         busValid     <= next_busValid;
         mainsPathOn  <= (next_src == SRC_MAINS);
         busPathOn    <= (next_src == SRC_BUS);
         batteryToSys <= (next_src == SRC_NONE);
         mainsSinkOn  <= next_mainsSinkOn;
         busSinkOn    <= next_busSinkOn;
      end
   end

   // Charge sequencer and safety timer
   logic [TW-1:0] tickCnt, next_tickCnt;
   logic [DW-1:0] detCnt, next_detCnt;
   logic [SW-1:0] safety, next_safety;
   logic halfPhase, next_halfPhase, tick, slow, tempOut, timersOn, termOk, restart, detEnd;
   logic next_done, next_fto, next_pto, next_tempErr, active;
   logic [SW-1:0] preLim, fastLim;

   always_comb
   begin
      tick     = (tickCnt == TW'(TICK_CYCLES - 1));
      next_tickCnt = tick ? '0 : tickCnt + TW'(1);
      detEnd   = (detCnt == DW'(DET_CYCLES - 1));
      // RULE22: temperature window
      tempOut  = fCold || (limitCfg[LIM_TEMP_WINDOW] ? fOver60 : fOver45);
      // RULE17: safety clock enable
      timersOn = ctrlCfg[CTRL_SAFETY_CLK] && !ctrlCfg[CTRL_END_DISABLE];
      // RULE15: slowdown enable
      slow     = optCfg[OPT_SLOWDOWN] && (fLoad || fThermal);
      // RULE14: no termination while reduced
      termOk   = !ctrlCfg[CTRL_END_DISABLE] && !fLoad && !fThermal;
      restart  = restartReq || (next_mainsValid && !mainsValid) || (next_busValid && !busValid);
      active   = (state == CH_PRE) || (state == CH_FAST) || (state == CH_CV);
      preLim   = SW'(PRE_LIMIT) << limitCfg[LIM_PRE_TIME +: 2];
      fastLim  = SW'(FAST_LIMIT) << ctrlCfg[CTRL_FAST_TIME +: 2];
      next_halfPhase = tick ? !halfPhase : halfPhase;
      next_safety = safety;
      // RULE14: half rate stepping
      if (tick && (!slow || halfPhase) && timersOn && !tempOut && active)
         next_safety = safety + SW'(1);
      next_detCnt  = detCnt + DW'(1);
      next_state   = state;
      next_done    = chargeDone;
      next_fto     = fastTimeout;
      next_pto     = preTimeout;
      next_tempErr = packTempError;
      if (!ctrlCfg[CTRL_ENABLE])
         next_state = CH_IDLE;
      else if (restart)
      begin
         // RULE21: clear faults and restart
         next_state = CH_SHORTCHK;
         next_done  = 1'b0;
         next_fto   = 1'b0;
         next_pto   = 1'b0;
      end
      else if (!(tempOut && active))
      begin
         unique case (state)
            // RULE9: enable starts short check
            CH_IDLE: next_state = CH_SHORTCHK;
            CH_SHORTCHK:
               if (fOverShort)
               begin
                  next_state  = CH_PRE;
                  next_safety = '0;
                  next_done   = 1'b0;
               end
            CH_PRE:
               // RULE10: precharge to fast charge
               if (fOverLowv)
               begin
                  next_state  = CH_FAST;
                  next_safety = '0;
               end
               // RULE20: precharge timeout
               else if (timersOn && safety >= preLim)
               begin
                  next_state = CH_FAULT;
                  next_pto   = 1'b1;
               end
            CH_FAST:
               if (fAtReg)
                  next_state = CH_CV;
               else if (timersOn && safety >= fastLim)
               begin
                  next_state = CH_FAULT;
                  next_fto   = 1'b1;
               end
            CH_CV:
               // RULE12: end current terminates
               if (termOk && fUnderEnd)
               begin
                  next_state = CH_DONE;
                  next_done  = 1'b1;
               end
               // RULE20: fast charge timeout
               else if (timersOn && safety >= fastLim)
               begin
                  next_state = CH_FAULT;
                  next_fto   = 1'b1;
               end
            CH_DONE:
               // RULE18: recharge detection
               if (fUnderRch)
               begin
                  next_state  = CH_DETECT;
                  next_detCnt = '0;
               end
            CH_DETECT:
               if (detEnd)
               begin
                  next_detCnt = '0;
                  if (fOverLowv)
                  begin
                     next_state = CH_SHORTCHK;
                  end
                  else
                  begin
                     // RULE19: removal flags temp error
                     next_state   = CH_INS_SRC;
                     next_tempErr = 1'b1;
                  end
               end
            CH_INS_SRC:
               if (detEnd)
               begin
                  next_detCnt = '0;
                  next_state  = fUnderRch ? CH_SHORTCHK : CH_INS_SINK;
                  next_tempErr = !fUnderRch;
               end
            CH_INS_SINK:
               // RULE19: alternate test pulses
               if (detEnd)
               begin
                  next_detCnt  = '0;
                  next_state   = fOverLowv ? CH_SHORTCHK : CH_INS_SRC;
                  next_tempErr = !fOverLowv;
               end
            CH_FAULT:
               // RULE21: below recharge restarts
               if (fUnderRch)
               begin
                  next_state = CH_SHORTCHK;
                  next_fto   = 1'b0;
                  next_pto   = 1'b0;
               end
            default: next_state = CH_IDLE;
         endcase
      end
      // RULE16: end disable turns a move to done into staying in constant voltage
      if (ctrlCfg[CTRL_END_DISABLE] && next_state == CH_DONE)
         next_state = CH_CV;
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state           <= CH_IDLE;
         tickCnt         <= '0;
         detCnt          <= '0;
         safety          <= '0;
         halfPhase       <= 1'b0;
         chargeDone      <= 1'b0;
         fastTimeout     <= 1'b0;
         preTimeout      <= 1'b0;
         packTempError   <= 1'b0;
         chargeOn        <= 1'b0;
         preCurrentOn    <= 1'b0;
         testSourceOn    <= 1'b0;
         testSinkOn      <= 1'b0;
         timerHalfRate   <= 1'b0;
         endCurrentCode  <= END_CODE_7P5;
         fastCurrentCode <= 2'h0;
      end
      else
      begin
         state         <= next_state;
         tickCnt       <= next_tickCnt;
         detCnt        <= next_detCnt;
         safety        <= next_safety;
         halfPhase     <= next_halfPhase;
         chargeDone    <= next_done;
         fastTimeout   <= next_fto;
         preTimeout    <= next_pto;
         packTempError <= next_tempErr;
         // RULE22: suspend outside window
         chargeOn      <= ((next_state == CH_PRE) || (next_state == CH_FAST)
                           || (next_state == CH_CV)) && !tempOut;
         // RULE11: fixed tenth current
         preCurrentOn  <= (next_state == CH_PRE) || (next_state == CH_INS_SRC);
         testSourceOn  <= (next_state == CH_SHORTCHK) || (next_state == CH_INS_SRC);
         testSinkOn    <= (next_state == CH_DETECT) || (next_state == CH_INS_SINK);
         timerHalfRate <= slow && active;
         // RULE13: end current select
         endCurrentCode  <= limitCfg[LIM_END_CURRENT +: 2];
         fastCurrentCode <= limitCfg[LIM_FAST_CURRENT +: 2];
      end
   end
endmodule

// [verilog/bcpc_pin_filter.sv]
// Three-stage synchroniser with agreement filter for comparator pins
`timescale 1ns/100ps
module bcpc_pin_filter
   import bcpc_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinOut
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;
   logic [W-1:0] next_pinOut;

   // A bit changes once the second and third stages agree
   always_comb
   begin
      next_pinOut = (stage2 & ~(stage2 ^ stage3)) | (pinOut & (stage2 ^ stage3));
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         pinOut <= '0;
      end
      else
      begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
         pinOut <= next_pinOut;
      end
   end
endmodule
